// file: acp_capture_model.sv
`timescale 1ns/1ps
// ==========================================================
// Capturing logic at the far side of the output link
module acp_capture_model (
  input  wire logic                         clk,
  input  wire logic                         strobe,
  input  wire logic [acp_pkg::SAMPLE_W-1:0] data,
  input  wire logic                         core_active,
  input  wire logic                         stall,
  input  wire logic                         fifo_valid,
  input  wire logic [acp_pkg::SAMPLE_W-1:0] fifo_data,
  output logic                              fifo_ready,
  output logic [acp_pkg::SAMPLE_W-1:0]      word,
  output logic                              fresh,
  output int                                pops,
  output logic [acp_pkg::SAMPLE_W-1:0]      pop_data
);
  int   settle   = 0;
  logic strobe_q = 1'b0;

  initial
  begin
    fifo_ready = 1'b0;
    word = 11'h000;
    pops = 0;
    pop_data = 11'h000;
  end

  // ==========================================================
  // Word capture; strobe sampled on the local clock
  always @(posedge clk)
  begin
    strobe_q <= strobe;
    if (!core_active)
      settle <= 0;
    else if (strobe && !strobe_q)
    begin
      word <= data;
      if (settle < 8)
        settle <= settle + 1;
    end
  end

  // Pipeline refill plus one word of margin
  assign fresh = (settle >= 8);

  // ==========================================================
  // FIFO drain, may stall
  // Registered on the sampling edge, so the design sees the old value
  always @(posedge clk)
  begin
    fifo_ready <= !stall;
  end

  always @(posedge clk)
  begin
    if (fifo_valid && fifo_ready)
    begin
      pops <= pops + 1;
      pop_data <= fifo_data;
    end
  end
endmodule

// file: acp_pkg.sv
package acp_pkg;

  // ==========================================================
  // Sizes and timing
  localparam int SAMPLE_W   = 11;
  localparam int IN_W       = 13;
  localparam int LATENCY    = 7;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================
  // Codes
  localparam logic [SAMPLE_W-1:0] CODE_POS_FULL = 11'h3ff;
  localparam logic [SAMPLE_W-1:0] CODE_NEG_FULL = 11'h400;
  localparam logic [SAMPLE_W-1:0] CODE_MSB      = 11'h400;
  localparam logic [SAMPLE_W-1:0] DATA_RST      = 11'h000;
  localparam logic [1:0]          SEL_FULL      = 2'h3;
  localparam logic [1:0]          SEL_TWO_THIRD = 2'h2;
  localparam logic [1:0]          SEL_ONE_THIRD = 2'h1;
  localparam logic [1:0]          SEL_GROUND    = 2'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0]
  {
    ACP_PWR_ON    = 2'h0,
    ACP_PWR_SLEEP = 2'h1,
    ACP_PWR_DOWN  = 2'h3
  } acp_pwr_t;

  typedef struct packed
  {
    logic                valid;
    logic [SAMPLE_W-1:0] code;
  } acp_word_t;

  typedef struct packed
  {
    logic diff_clk;
    logic twos;
  } acp_cfg_t;

endpackage

// file: acp_sample_pipeline.sv
`timescale 1ns/1ps

// ==========================================================
// Sample FIFO
module acp_fifo #(
  parameter int W     = 11,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_reg;
  logic [AW:0]  rd_ptr_reg;
  logic         out_valid_reg;
  logic [W-1:0] out_data_reg;
  logic         empty;
  logic         push;
  logic         pop;

  assign empty     = wr_ptr_reg == rd_ptr_reg;
  assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW])
                     && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign push      = in_valid && in_ready;
  assign pop       = !empty && (!out_valid_reg || out_ready);
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      wr_ptr_reg <= '0;
    else if (push)
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
  end

  // Output register keeps the drain side timing-clean
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_ptr_reg    <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else if (pop)
    begin
      rd_ptr_reg    <= rd_ptr_reg + 1'b1;
      out_valid_reg <= 1'b1;
      out_data_reg  <= mem[rd_ptr_reg[AW-1:0]];
    end
    else if (out_ready)
      out_valid_reg <= 1'b0;
  end

  AST_FIFO_FULL_REFUSES: assert property (@(posedge clk) disable iff (rst)
    !in_ready |=> wr_ptr_reg == $past(wr_ptr_reg))
    else $error("FIFO written while full");
endmodule

// ==========================================================
// Converter output pipeline
module acp_sample_pipeline #(
  parameter int LATENCY = acp_pkg::LATENCY
) (
  input  wire logic                              REF_CLK,
  input  wire logic                              RST,
  input  wire logic                              CONV_CLK,
  input  wire logic signed [acp_pkg::IN_W-1:0]   ANALOG_IN,
  input  wire logic [1:0]                        POWER_STATE_INPUT,
  input  wire logic [1:0]                        CLOCK_FORMAT_SELECT,
  output logic [acp_pkg::SAMPLE_W-1:0]           DATA_OUT,
  output logic                                   SAMPLE_STROBE_OUT,
  output logic                                   CLK_DIFF_MODE,
  output logic                                   CORE_ACTIVE,
  output logic                                   REF_BUF_ACTIVE,
  output logic                                   FIFO_VALID,
  input  wire logic                              FIFO_READY,
  output logic [acp_pkg::SAMPLE_W-1:0]           FIFO_DATA,
  output logic                                   FIFO_DROP
);
  localparam int SW = acp_pkg::SAMPLE_W;

  if (LATENCY < 1 || LATENCY > 16)
  begin : g_bad_latency
    $error("LATENCY out of range");
  end

  // ==========================================================
  // Conversion clock domain
  logic                c_rst_s1;
  logic                c_rst;
  logic [1:0]          c_pwr_s1;
  logic [1:0]          c_pwr_s2;
  logic                c_on;
  acp_pkg::acp_word_t  samp_reg;
  acp_pkg::acp_word_t  samp_next;
  acp_pkg::acp_word_t  pipe_reg [LATENCY];
  logic                fall_tog_reg;
  logic                rise_tog_reg;

  assign c_on = acp_pkg::acp_pwr_t'(c_pwr_s2) == acp_pkg::ACP_PWR_ON;

  always_ff @(negedge CONV_CLK)
  begin
    c_rst_s1 <= RST;
    c_rst    <= c_rst_s1;
    c_pwr_s1 <= POWER_STATE_INPUT;
    c_pwr_s2 <= c_pwr_s1;
  end

  // Clamp to the 11-bit range instead of wrapping
  always_comb
  begin
    samp_next.valid = c_on;
    if (ANALOG_IN > $signed({{(acp_pkg::IN_W-SW){1'b0}},
                             acp_pkg::CODE_POS_FULL}))
      samp_next.code = acp_pkg::CODE_POS_FULL;
    else if (ANALOG_IN < -$signed({{(acp_pkg::IN_W-SW){1'b0}},
                                  acp_pkg::CODE_MSB}))
      samp_next.code = acp_pkg::CODE_NEG_FULL;
    else
      samp_next.code = ANALOG_IN[SW-1:0];
  end

  // Hold phase starts at the falling edge
  always_ff @(negedge CONV_CLK)
  begin
    if (c_rst)
      samp_reg <= '0;
    else
      samp_reg <= samp_next;
  end

  genvar gi;
  generate
    for (gi = 0; gi < LATENCY; gi++)
    begin : g_stage
      always_ff @(negedge CONV_CLK)
      begin
        if (c_rst || !c_on)
          pipe_reg[gi] <= '0;
        else if (gi == 0)
          pipe_reg[gi] <= samp_reg;
        else
          pipe_reg[gi] <= pipe_reg[(gi == 0) ? 0 : gi-1];
      end
    end
  endgenerate

  // Toggles stop while the core is off, so the strobe stops too
  always_ff @(negedge CONV_CLK)
  begin
    if (c_rst)
      fall_tog_reg <= 1'b0;
    else if (c_on)
      fall_tog_reg <= !fall_tog_reg;
  end

  always_ff @(posedge CONV_CLK)
  begin
    if (c_rst)
      rise_tog_reg <= 1'b0;
    else if (c_on)
      rise_tog_reg <= !rise_tog_reg;
  end

  AST_POS_SATURATE: assert property (@(negedge CONV_CLK)
    disable iff (c_rst)
    (c_on && ANALOG_IN > 13'sd1023) |=> samp_reg.code == 11'h3ff)
    else $error("Positive overrange not saturated");

  AST_NEG_SATURATE: assert property (@(negedge CONV_CLK)
    disable iff (c_rst)
    (c_on && ANALOG_IN < -13'sd1024) |=> samp_reg.code == 11'h400)
    else $error("Negative overrange not saturated");

  AST_LATENCY: assert property (@(negedge CONV_CLK)
    disable iff (c_rst)
    pipe_reg[LATENCY-1].valid
      |-> pipe_reg[LATENCY-1] == $past(samp_reg, LATENCY))
    else $error("Pipeline delay wrong");

  // ==========================================================
  // Reference clock domain
  logic                  f_s1;
  logic                  f_s2;
  logic                  f_s3;
  logic                  r_s1;
  logic                  r_s2;
  logic                  r_s3;
  logic [1:0]            pwr_s1;
  logic [1:0]            pwr_s2;
  logic [1:0]            sel_s1;
  logic [1:0]            sel_s2;
  logic                  on_r;
  logic                  load;
  logic                  rise;
  acp_pkg::acp_word_t    cross_word;
  acp_pkg::acp_cfg_t     cfg_reg;
  logic [SW-1:0]         data_reg;
  logic [SW-1:0]         data_next;
  logic                  strobe_reg;
  logic                  core_reg;
  logic                  refbuf_reg;
  logic                  drop_reg;
  logic                  fifo_in_ready;

  always_ff @(posedge REF_CLK)
  begin
    f_s1   <= fall_tog_reg;
    f_s2   <= f_s1;
    f_s3   <= f_s2;
    r_s1   <= rise_tog_reg;
    r_s2   <= r_s1;
    r_s3   <= r_s2;
    pwr_s1 <= POWER_STATE_INPUT;
    pwr_s2 <= pwr_s1;
    sel_s1 <= CLOCK_FORMAT_SELECT;
    sel_s2 <= sel_s1;
  end

  assign on_r = acp_pkg::acp_pwr_t'(pwr_s2) == acp_pkg::ACP_PWR_ON;
  assign load = f_s2 ^ f_s3;
  assign rise = r_s2 ^ r_s3;
  // Last stage is stable for a whole conversion period after its toggle
  assign cross_word = pipe_reg[LATENCY-1];
  assign data_next  = cross_word.code
                      ^ (cfg_reg.twos ? acp_pkg::DATA_RST : acp_pkg::CODE_MSB);

  // Upper select bit picks clock mode, lower bit picks coding
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      cfg_reg <= '0;
    else
    begin
      cfg_reg.diff_clk <= sel_s2[1];
      cfg_reg.twos     <= sel_s2[0];
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      core_reg   <= 1'b0;
      refbuf_reg <= 1'b0;
    end
    else
    begin
      core_reg   <= on_r;
      refbuf_reg <= acp_pkg::acp_pwr_t'(pwr_s2)
                    != acp_pkg::ACP_PWR_DOWN;
    end
  end

  // Word and strobe fall in the same edge
  always_ff @(posedge REF_CLK)
  begin
    if (RST || !on_r)
    begin
      data_reg   <= acp_pkg::DATA_RST;
      strobe_reg <= 1'b0;
    end
    else if (load)
    begin
      data_reg   <= data_next;
      strobe_reg <= 1'b0;
    end
    else if (rise)
      strobe_reg <= 1'b1;
  end

  // Drain side can stall; an overrun shows as a one-cycle drop pulse
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      drop_reg <= 1'b0;
    else
      drop_reg <= load && on_r && cross_word.valid && !fifo_in_ready;
  end

  acp_fifo #(
    .W     (SW),
    .DEPTH (acp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst       (RST),
    .in_valid  (load && on_r && cross_word.valid),
    .in_ready  (fifo_in_ready),
    .in_data   (data_next),
    .out_valid (FIFO_VALID),
    .out_ready (FIFO_READY),
    .out_data  (FIFO_DATA)
  );

  assign DATA_OUT          = data_reg;
  assign SAMPLE_STROBE_OUT = strobe_reg;
  assign CLK_DIFF_MODE     = cfg_reg.diff_clk;
  assign CORE_ACTIVE       = core_reg;
  assign REF_BUF_ACTIVE    = refbuf_reg;
  assign FIFO_DROP         = drop_reg;

  sequence s_strobe_low;
    !SAMPLE_STROBE_OUT;
  endsequence

  sequence s_strobe_back;
    ##[1:1000] SAMPLE_STROBE_OUT;
  endsequence

  AST_DATA_ON_FALL: assert property (@(posedge REF_CLK)
    disable iff (RST)
    $changed(DATA_OUT) && on_r && $past(on_r)
      |-> !SAMPLE_STROBE_OUT
          && ($fell(SAMPLE_STROBE_OUT) || $past(!SAMPLE_STROBE_OUT)))
    else $error("Output word changed off the strobe fall");

  AST_STROBE_RETURNS: assert property (@(posedge REF_CLK)
    disable iff (RST)
    ($fell(SAMPLE_STROBE_OUT) && on_r) |-> s_strobe_low
      ##0 (s_strobe_back or (##[1:1000] !on_r)))
    else $error("Strobe did not return high");

  AST_CODING: assert property (@(posedge REF_CLK)
    disable iff (RST)
    (load && on_r) |=> DATA_OUT == ($past(cross_word.code)
      ^ ($past(cfg_reg.twos) ? 11'h000 : 11'h400)))
    else $error("Output coding wrong");

  AST_POWER_OFF: assert property (@(posedge REF_CLK)
    disable iff (RST)
    !on_r |=> (DATA_OUT == 11'h000 && !SAMPLE_STROBE_OUT && !CORE_ACTIVE))
    else $error("Outputs active while powered off");

  AST_SLEEP_BUFFER: assert property (@(posedge REF_CLK)
    disable iff (RST)
    pwr_s2 == 2'h1 |=> REF_BUF_ACTIVE && !CORE_ACTIVE)
    else $error("Sleep state wrong");

  AST_SELECT_DECODE: assert property (@(posedge REF_CLK)
    disable iff (RST)
    sel_s2 == 2'h2 |=> CLK_DIFF_MODE && !cfg_reg.twos)
    else $error("Select decode wrong");
endmodule

// file: test_adc_sample_output_pipeline.sv
`timescale 1ns/1ps
module test_adc_sample_output_pipeline;
  logic               ref_clk  = 1'b0;
  logic               conv_clk = 1'b0;
  logic               rst      = 1'b1;
  logic               stall    = 1'b0;
  logic signed [12:0] ain      = 13'sh0000;
  logic [1:0]         pwr      = acp_pkg::ACP_PWR_ON;
  logic [1:0]         sel      = acp_pkg::SEL_GROUND;
  logic [10:0]        dout;
  logic [10:0]        fdata;
  logic [10:0]        word;
  logic [10:0]        pop_data;
  logic               strobe;
  logic               diff;
  logic               core;
  logic               refbuf;
  logic               fvalid;
  logic               fready;
  logic               fdrop;
  logic               fresh;
  int                 pops;
  int                 drops  = 0;
  int                 cycles = 0;
  int                 n_fail = 0;
  int                 checked = 0;

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Conversion clock with an unrelated phase
  initial
  begin
    #37.3;
    forever #80 conv_clk = ~conv_clk;
  end

  acp_sample_pipeline dut (
    .REF_CLK(ref_clk), .RST(rst), .CONV_CLK(conv_clk), .ANALOG_IN(ain),
    .POWER_STATE_INPUT(pwr), .CLOCK_FORMAT_SELECT(sel), .DATA_OUT(dout),
    .SAMPLE_STROBE_OUT(strobe), .CLK_DIFF_MODE(diff), .CORE_ACTIVE(core),
    .REF_BUF_ACTIVE(refbuf), .FIFO_VALID(fvalid), .FIFO_READY(fready),
    .FIFO_DATA(fdata), .FIFO_DROP(fdrop)
  );

  acp_capture_model far (
    .clk(ref_clk), .strobe(strobe), .data(dout), .core_active(core),
    .stall(stall), .fifo_valid(fvalid), .fifo_data(fdata),
    .fifo_ready(fready), .word(word), .fresh(fresh), .pops(pops),
    .pop_data(pop_data)
  );

  // ==========================================================
  // Checking helpers
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic [10:0] exp_code(input int v, input logic [1:0] s);
    int          c;
    logic [10:0] r;
    c = (v > 1023) ? 1023 : ((v < -1024) ? -1024 : v);
    r = c[10:0];
    if (s == acp_pkg::SEL_GROUND || s == acp_pkg::SEL_TWO_THIRD)
      r[10] = ~r[10];
    return r;
  endfunction

  task automatic falls(input int n);
    repeat (n) @(negedge conv_clk);
    @(negedge ref_clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_coding();
    int vals[7] = '{-3000, -1024, -512, 0, 512, 1023, 3000};
    for (int s = 0; s < 4; s++)
    begin
      foreach (vals[i])
      begin
        sel = s[1:0];
        ain = vals[i][12:0];
        falls(10);
        chk(word, exp_code(vals[i], s[1:0]));
        chk1(diff, s[1]);
      end
    end
    $display("test coding done");
  endtask

  task automatic t_latency();
    sel = acp_pkg::SEL_GROUND;
    ain = 13'sd100;
    falls(10);
    @(negedge conv_clk);
    @(negedge ref_clk);
    ain = -13'sd100;
    @(negedge conv_clk);
    @(negedge ref_clk);
    ain = 13'sd300;
    falls(6);
    repeat (5) @(negedge ref_clk);
    chk(dout, exp_code(100, sel));
    falls(1);
    repeat (5) @(negedge ref_clk);
    chk(dout, exp_code(-100, sel));
    chk1(strobe, 1'b0);
    falls(1);
    repeat (5) @(negedge ref_clk);
    chk(dout, exp_code(300, sel));
    $display("test latency done");
  endtask

  task automatic t_strobe();
    int   n;
    logic q;
    n = 0;
    q = strobe;
    @(negedge conv_clk);
    repeat (256)
    begin
      @(negedge ref_clk);
      if (strobe === 1'b1 && q === 1'b0)
        n++;
      q = strobe;
    end
    chk(n[10:0], 11'h008);
    $display("test strobe done");
  endtask

  task automatic t_power();
    pwr = acp_pkg::ACP_PWR_DOWN;
    falls(4);
    chk1(core, 1'b0);
    chk1(refbuf, 1'b0);
    chk(dout, acp_pkg::DATA_RST);
    pwr = acp_pkg::ACP_PWR_SLEEP;
    falls(4);
    chk1(core, 1'b0);
    chk1(refbuf, 1'b1);
    chk1(strobe, 1'b0);
    pwr = acp_pkg::ACP_PWR_ON;
    ain = 13'sd500;
    falls(12);
    chk1(core, 1'b1);
    chk1(fresh, 1'b1);
    chk(word, exp_code(500, sel));
    $display("test power done");
  endtask

  task automatic t_fifo();
    int p0;
    stall = 1'b1;
    falls(14);
    chk1(drops > 0, 1'b1);
    chk1(fvalid, 1'b1);
    p0 = pops;
    stall = 1'b0;
    repeat (16) @(negedge ref_clk);
    // Depth plus output register, one late push may slip in
    chk1((pops - p0 >= 9) && (pops - p0 <= 10), 1'b1);
    chk(pop_data, exp_code(500, sel));
    $display("test fifo done");
  endtask

  // ==========================================================
  // Monitors and ending
  always @(posedge ref_clk)
  begin
    if (fdrop === 1'b1)
      drops++;
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      $display("[FAIL] %0t run did not finish", $time);
      final_report();
    end
  end

  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    // Conversion domain needs several conversion periods of reset
    repeat (100) @(negedge ref_clk);
    rst = 1'b0;
    falls(2);
    t_latency();
    t_coding();
    t_strobe();
    t_power();
    t_fifo();
    final_report();
  end
endmodule
